// ==== shared/dsfc_pkg.sv ====
// Constants and types for the DPLL switchover and fast-lock controller
package dsfc_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

    localparam int FREQ_W  = 32;
    localparam int PHASE_W = 32;
    localparam int BW_W    = 8;
    localparam int SLOPE_W = 17;
    localparam int MS_W    = 8;
    localparam int STEP_W  = 4;

    // Slope codes in ns/s; zero means limited only by loop bandwidth
    localparam logic [SLOPE_W-1:0] SLOPE_UNLIMITED = 17'h00000;
    localparam logic [SLOPE_W-1:0] SLOPE_MAX       = 17'h10000;
    localparam logic [SLOPE_W-1:0] SLOPE_61US      = 17'h0EE48;
    localparam logic [SLOPE_W-1:0] SLOPE_7US5      = 17'h01D4C;
    localparam logic [SLOPE_W-1:0] SLOPE_885NS     = 17'h00375;

    localparam logic [BW_W-1:0] BW_MAX = 8'hFF;

    // Bit positions within one nibble of fast_lock_option_enables, then the offset of the relock nibble
    localparam int FL_FREQ_SNAP  = 0;
    localparam int FL_PHASE_SNAP = 1;
    localparam int FL_OPEN_LOOP  = 2;
    localparam int FL_WIDE_BW    = 3;
    localparam int FL_RELOCK_OFS = 4;

    // Bit positions within wide_acq_limit_select
    localparam int WS_BW   = 0;
    localparam int WS_PSL  = 1;
    localparam int WS_DAMP = 2;

    localparam logic [7:0] LFSR_SEED = 8'hA5;

    typedef enum logic [4:0] {
        ST_HOLD    = 5'h01,
        ST_ACQ     = 5'h02,
        ST_HITLESS = 5'h04,
        ST_RELOCK  = 5'h08,
        ST_LOCKED  = 5'h10
    } dsfc_state_t;
endpackage

// ==== logic/dsfc_switch_ctrl.sv ====
// DPLL reference switchover, hitless re-zeroing, limits and fast-lock sequencing
// Summary of operation
// - Switching is non-revertive unless the revertive control bit is set.
// - Selection picks the qualified reference with the highest priority, then locks.
// - Non-revertive mode leaves the current reference only once it becomes invalid.
// - Revertive mode moves to a better reference unless both share a group.
// - Hitless switching is enabled per DPLL; triggers on ref change and on holdover exit after an earlier lock.
// - A hitless change passes through temporary holdover with no holdover alarm.
// - Measured initial phase offset becomes phase detector zero; tracking keeps it.
// - Leaving holdover with hitless enabled, after an earlier lock, measures the offset before tracking.
// - Type 1 residual depends on new reference frequency, type 2 does not.
// - Type 2 events give satellite outputs small random, accumulating phase steps.
// - Phase slope limiting is enabled per DPLL, 1 ns/s to 65.536 us/s.
// - Slope code zero is unlimited; telecom limit values are representable.
// - Frequency is clamped to the programmed maximum offset in every state.
// - Fast-lock options enable separately; precedence freq snap, phase snap, pull-in, wide.
// - Open-loop pull-in and phase snap are never active together.
// - Frequency snap loads the measured offset into the divider, optionally slope bounded.
// - Phase snap loads measured phase; open-loop pull-in bypasses detector and filter.
// - Wide acquisition relaxes bandwidth, slope and damping until lock, then restores.
// - Pre-acquisition opens bandwidth fully for programmed ms, acquisition only, first.
// - With every input invalid the DPLL enters holdover on stored frequency.
module dsfc_switch_ctrl
    import dsfc_pkg::*;
#(
    parameter int NUM_REFS      = 4,
    parameter int PRIO_W        = 4,
    parameter int GROUP_W       = 3,
    parameter int MS_CYCLES     = CYCLES_PER_MS
) (
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    input  wire logic [NUM_REFS-1:0]           refValid,
    input  wire logic [NUM_REFS-1:0]           refEnable,
    input  wire logic [NUM_REFS*PRIO_W-1:0]    refPriority,
    input  wire logic [NUM_REFS*GROUP_W-1:0]   refGroup,
    input  wire logic                          revertiveEnable,
    input  wire logic                          hitlessEnable,
    input  wire logic                          hitlessType2,
    input  wire logic                          pslEnable,
    input  wire logic [dsfc_pkg::SLOPE_W-1:0]  phaseSlopeLimitValue,
    input  wire logic [dsfc_pkg::FREQ_W-2:0]   maxFreqOffsetLimit,
    input  wire logic [7:0]                    fastLockOptionEnables,
    input  wire logic [2:0]                    wideAcqLimitSelect,
    input  wire logic [dsfc_pkg::SLOPE_W-1:0]  fastLockSlopeLimit,
    input  wire logic [dsfc_pkg::BW_W-1:0]     fastLockBandwidth,
    input  wire logic [dsfc_pkg::BW_W-1:0]     loopBandwidth,
    input  wire logic                          preAcqEnable,
    input  wire logic [dsfc_pkg::MS_W-1:0]     preAcqMs,
    input  wire logic [dsfc_pkg::FREQ_W-2:0]   freqSnapSlopeLimit,
    input  wire logic                          lockDetect,
    input  wire logic                          phaseMeasDone,
    input  wire logic [dsfc_pkg::PHASE_W-1:0]  phaseMeas,
    input  wire logic [dsfc_pkg::PHASE_W-1:0]  phaseFreqTerm,
    input  wire logic [dsfc_pkg::PHASE_W-1:0]  phaseDetRaw,
    input  wire logic [dsfc_pkg::FREQ_W-1:0]   freqOffsetMeas,
    input  wire logic [dsfc_pkg::FREQ_W-1:0]   freqRequest,
    output dsfc_pkg::dsfc_state_t              state,
    output logic [$clog2(NUM_REFS)-1:0]        selectedRef,
    output logic                               holdoverAlarm,
    output logic [dsfc_pkg::PHASE_W-1:0]       phaseZero,
    output logic [dsfc_pkg::PHASE_W-1:0]       phaseError,
    output logic [dsfc_pkg::FREQ_W-1:0]        freqSteer,
    output logic                               freqSnapLoad,
    output logic [dsfc_pkg::FREQ_W-1:0]        freqSnapValue,
    output logic                               phaseSnapLoad,
    output logic [dsfc_pkg::PHASE_W-1:0]       phaseSnapValue,
    output logic                               openLoopActive,
    output logic                               preAcqActive,
    output logic                               wideBwActive,
    output logic [dsfc_pkg::SLOPE_W-1:0]       activeSlopeLimit,
    output logic [dsfc_pkg::BW_W-1:0]          activeBandwidth,
    output logic                               dampingRelaxed,
    output logic                               satStepLoad,
    output logic [dsfc_pkg::STEP_W-1:0]        satStepValue
);
    import dsfc_pkg::*;
    localparam int SEL_W = $clog2(NUM_REFS);

    logic [NUM_REFS-1:0] validMeta;
    logic [NUM_REFS-1:0] validSync;
    logic [NUM_REFS-1:0] qual;
    logic                bestFound;
    logic [SEL_W-1:0]    bestRef;
    logic [PRIO_W-1:0]   bestPrio;
    logic [PRIO_W-1:0]   curPrio;
    logic [GROUP_W-1:0]  curGroup;
    logic [GROUP_W-1:0]  bestGroup;
    logic                trackState;
    logic                curQual;
    logic                betterRef;
    logic                switchReq;
    logic                hadLock;
    logic                hsFromHold;
    dsfc_state_t         next_state;
    logic                enterFast;
    logic [3:0]          fastEn;
    logic [15:0]         cycleCnt;
    logic [MS_W-1:0]     msLeft;
    logic [7:0]          lfsr;
    logic [FREQ_W-1:0]   snapBound;
    logic signed [FREQ_W:0] snapStep;

    function automatic logic [FREQ_W-1:0] clampS(input logic signed [FREQ_W:0] v,
                                                 input logic [FREQ_W-2:0] lim);
        logic signed [FREQ_W:0] hi;
        hi = $signed({2'b00, lim});
        if (v > hi) clampS = hi[FREQ_W-1:0];
        else if (v < -hi) clampS = FREQ_W'(-hi);
        else clampS = v[FREQ_W-1:0];
    endfunction

    // Monitor flags come from another domain
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            validMeta <= '0;
            validSync <= '0;
        end else begin
            validMeta <= refValid;
            validSync <= validMeta;
        end
    end

    assign qual = validSync & refEnable;

    always_comb begin
        bestFound = 1'b0;
        bestRef   = '0;
        bestPrio  = '1;
        // Strict compare: among equal priorities the lowest index wins
        for (int i = 0; i < NUM_REFS; i++) begin
            if (qual[i] && (!bestFound || refPriority[i*PRIO_W +: PRIO_W] < bestPrio)) begin
                bestFound = 1'b1;
                bestRef   = SEL_W'(i);
                bestPrio  = refPriority[i*PRIO_W +: PRIO_W];
            end
        end
    end

    assign curPrio    = refPriority[selectedRef*PRIO_W +: PRIO_W];
    assign curGroup   = refGroup[selectedRef*GROUP_W +: GROUP_W];
    assign bestGroup  = refGroup[bestRef*GROUP_W +: GROUP_W];
    assign curQual    = qual[selectedRef];
    assign trackState = state == ST_ACQ || state == ST_RELOCK || state == ST_LOCKED;
    // Group zero means no equal-priority group
    assign betterRef  = bestFound && bestPrio < curPrio && bestRef != selectedRef
                        && !(curGroup != '0 && curGroup == bestGroup);
    assign switchReq  = trackState && bestFound
                        && (!curQual || (revertiveEnable && betterRef));

    always_comb begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                if (bestFound)
                    next_state = (hitlessEnable && hadLock) ? ST_HITLESS : ST_ACQ;
            end
            ST_HITLESS: begin
                if (!curQual) next_state = ST_HOLD;
                else if (phaseMeasDone) next_state = hsFromHold ? ST_ACQ : ST_RELOCK;
            end
            default: begin
                if (!curQual && !bestFound) next_state = ST_HOLD;
                else if (switchReq) next_state = hitlessEnable ? ST_HITLESS : ST_RELOCK;
                else if (state != ST_LOCKED && lockDetect) next_state = ST_LOCKED;
                else if (state == ST_LOCKED && !lockDetect) next_state = ST_RELOCK;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state         <= ST_HOLD;
            selectedRef   <= '0;
            hadLock       <= 1'b0;
            hsFromHold    <= 1'b0;
            holdoverAlarm <= 1'b1;
        end else begin
            state         <= next_state;
            // Temporary holdover of a hitless change keeps the alarm quiet
            holdoverAlarm <= next_state == ST_HOLD;
            if (state == ST_LOCKED) hadLock <= 1'b1;
            if ((state == ST_HOLD && bestFound) || switchReq) begin
                selectedRef <= bestRef;
                hsFromHold  <= state == ST_HOLD;
            end
        end
    end

    // Phase detector zero point and tracking error
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phaseZero  <= '0;
            phaseError <= '0;
        end else begin
            if (state == ST_HITLESS && phaseMeasDone && curQual) begin
                // Type 2 removes the frequency-dependent part of the offset
                phaseZero <= hitlessType2 ? phaseMeas - phaseFreqTerm : phaseMeas;
            end else if (next_state == ST_ACQ && state == ST_HOLD) begin
                phaseZero <= '0;
            end else if (switchReq && !hitlessEnable) begin
                phaseZero <= '0;
            end
            phaseError <= phaseDetRaw - phaseZero;
        end
    end

    // Satellite phase steps: accumulation is downstream, one step per type 2 event
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lfsr         <= LFSR_SEED;
            satStepLoad  <= 1'b0;
            satStepValue <= '0;
        end else begin
            lfsr        <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            satStepLoad <= state == ST_HITLESS && phaseMeasDone && curQual
                           && hitlessType2;
            if (state == ST_HITLESS && phaseMeasDone)
                satStepValue <= lfsr[STEP_W-1:0];
        end
    end

    assign enterFast = (next_state == ST_ACQ && state != ST_ACQ)
                       || (next_state == ST_RELOCK && state != ST_RELOCK);
    assign fastEn    = next_state == ST_ACQ ? fastLockOptionEnables[3:0]
                       : fastLockOptionEnables[FL_RELOCK_OFS +: 4];
    // Bounded step keeps its sign; a negative offset must not turn positive
    assign snapBound = clampS($signed({freqOffsetMeas[FREQ_W-1], freqOffsetMeas}), freqSnapSlopeLimit);
    assign snapStep  = freqSnapSlopeLimit != '0 ? $signed({snapBound[FREQ_W-1], snapBound})
                       : $signed({freqOffsetMeas[FREQ_W-1], freqOffsetMeas});

    // Fast-lock sequencing; only the highest-precedence enabled option runs
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            freqSnapLoad   <= 1'b0;
            freqSnapValue  <= '0;
            phaseSnapLoad  <= 1'b0;
            phaseSnapValue <= '0;
            openLoopActive <= 1'b0;
            preAcqActive   <= 1'b0;
            wideBwActive   <= 1'b0;
            cycleCnt       <= '0;
            msLeft         <= '0;
        end else begin
            freqSnapLoad  <= 1'b0;
            phaseSnapLoad <= 1'b0;
            if (enterFast) begin
                openLoopActive <= 1'b0;
                preAcqActive   <= 1'b0;
                wideBwActive   <= 1'b0;
                if (fastEn[FL_FREQ_SNAP]) begin
                    freqSnapLoad  <= 1'b1;
                    freqSnapValue <= clampS($signed({freqSteer[FREQ_W-1], freqSteer})
                                            + snapStep, maxFreqOffsetLimit);
                end else if (fastEn[FL_PHASE_SNAP]) begin
                    phaseSnapLoad  <= 1'b1;
                    phaseSnapValue <= phaseDetRaw;
                end else if (fastEn[FL_OPEN_LOOP]) begin
                    openLoopActive <= 1'b1;
                end else if (fastEn[FL_WIDE_BW]) begin
                    if (next_state == ST_ACQ && preAcqEnable && preAcqMs != '0) begin
                        preAcqActive <= 1'b1;
                        msLeft       <= preAcqMs;
                        cycleCnt     <= '0;
                    end else begin
                        wideBwActive <= 1'b1;
                    end
                end
            end else if (!(state == ST_ACQ || state == ST_RELOCK)) begin
                openLoopActive <= 1'b0;
                preAcqActive   <= 1'b0;
                wideBwActive   <= 1'b0;
            end else if (preAcqActive) begin
                if (cycleCnt == 16'(MS_CYCLES - 1)) begin
                    cycleCnt <= '0;
                    msLeft   <= msLeft - 1'b1;
                    if (msLeft == 8'h01) begin
                        preAcqActive <= 1'b0;
                        wideBwActive <= 1'b1;
                    end
                end else begin
                    cycleCnt <= cycleCnt + 16'h0001;
                end
            end
        end
    end

    // Effective loop limits and clamped frequency
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            activeSlopeLimit <= SLOPE_UNLIMITED;
            activeBandwidth  <= '0;
            dampingRelaxed   <= 1'b0;
            freqSteer        <= '0;
        end else begin
            if (!pslEnable)
                activeSlopeLimit <= SLOPE_UNLIMITED;
            else if (preAcqActive || (wideBwActive && wideAcqLimitSelect[WS_PSL]))
                activeSlopeLimit <= fastLockSlopeLimit > SLOPE_MAX ? SLOPE_MAX
                                    : fastLockSlopeLimit;
            else
                activeSlopeLimit <= phaseSlopeLimitValue > SLOPE_MAX ? SLOPE_MAX
                                    : phaseSlopeLimitValue;
            if (preAcqActive)
                activeBandwidth <= BW_MAX;
            else if (wideBwActive && wideAcqLimitSelect[WS_BW])
                activeBandwidth <= fastLockBandwidth;
            else
                activeBandwidth <= loopBandwidth;
            dampingRelaxed <= wideBwActive && wideAcqLimitSelect[WS_DAMP];
            freqSteer <= clampS($signed({freqRequest[FREQ_W-1], freqRequest}),
                                maxFreqOffsetLimit);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    hitless_no_alarm_a: assert property (state == ST_HITLESS |-> !holdoverAlarm)
        else $error("holdover alarm raised during hitless change");
    all_invalid_hold_a: assert property (trackState && qual == '0 |=> state == ST_HOLD)
        else $error("no holdover with every input invalid");
    nonrev_stay_a: assert property (!revertiveEnable && trackState && curQual
                                     |=> $stable(selectedRef))
        else $error("non-revertive switch while current reference valid");
    revert_switch_a: assert property (revertiveEnable && trackState && curQual && betterRef
                                      |=> selectedRef == $past(bestRef))
        else $error("revertive switch to better reference missing");
    hitless_entry_a: assert property (switchReq && hitlessEnable |=> state == ST_HITLESS)
        else $error("hitless switch did not enter temporary holdover");
    zero_capture_a: assert property (state == ST_HITLESS && phaseMeasDone && curQual
                                     && !hitlessType2 |=> phaseZero == $past(phaseMeas))
        else $error("phase zero not captured");
    snap_excl_a: assert property (!(phaseSnapLoad && openLoopActive))
        else $error("phase snap and open loop pull-in together");
    freq_clamp_a: assert property ($past(maxFreqOffsetLimit) == maxFreqOffsetLimit
                                   |-> $signed(freqSteer) <= $signed({1'b0, maxFreqOffsetLimit})
                                   && $signed(freqSteer) >= -$signed({1'b0, maxFreqOffsetLimit}))
        else $error("frequency exceeds maximum offset");
    preacq_first_a: assert property (preAcqActive |-> !wideBwActive && state == ST_ACQ
                                     && activeBandwidth == BW_MAX || $rose(preAcqActive))
        else $error("pre-acquisition overlaps wide bandwidth");
    slope_off_a: assert property (!pslEnable |=> activeSlopeLimit == SLOPE_UNLIMITED)
        else $error("slope limit applied while disabled");

    hitless_cov: cover property (state == ST_HITLESS ##[1:50] state == ST_RELOCK);
    revert_cov: cover property (revertiveEnable && betterRef && curQual && trackState);
    preacq_cov: cover property ($fell(preAcqActive) && wideBwActive);
    holdover_cov: cover property (state == ST_LOCKED ##1 state == ST_HOLD);
endmodule // dsfc_switch_ctrl

// ==== tb/dsfc_ref_model.sv ====
// Reference monitor and loop response model facing the switchover controller
module dsfc_ref_model (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic [3:0]            wantValid,
    input  wire logic [3:0]            lagCycles,
    input  wire logic [7:0]            lockCycles,
    input  wire dsfc_pkg::dsfc_state_t state,
    output logic [3:0]                 refValid,
    output logic                       lockDetect,
    output logic                       phaseMeasDone
);
    timeunit 1ns;
    timeprecision 1ps;
    import dsfc_pkg::*;
    logic [3:0] lagCount;
    logic [7:0] lockCount;
    // Qualification lags the request, as a monitor needs time to judge an input
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            refValid <= 4'h0;
            lagCount <= 4'h0;
        end else if (refValid == wantValid) begin
            lagCount <= 4'h0;
        end else if (lagCount >= lagCycles) begin
            refValid <= wantValid;
            lagCount <= 4'h0;
        end else begin
            lagCount <= lagCount + 4'h1;
        end
    end
    // Loop reports lock only after settling; a stale lock flag would skip re-acquisition
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lockCount <= 8'h00;
        end else if (state == ST_ACQ || state == ST_RELOCK) begin
            lockCount <= lockCount + 8'h01;
        end else begin
            lockCount <= 8'h00;
        end
    end
    assign lockDetect = state == ST_LOCKED
                        || ((state == ST_ACQ || state == ST_RELOCK) && lockCount >= lockCycles);
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) phaseMeasDone <= 1'b0;
        else phaseMeasDone <= (state == ST_HITLESS) && !phaseMeasDone;
    end
endmodule // dsfc_ref_model

// ==== tb/testbench.sv ====
// Self-checking bench for the switchover and fast-lock controller
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dsfc_pkg::*;
    logic clk_sys, reset, revertiveEnable, hitlessEnable, hitlessType2, pslEnable;
    logic preAcqEnable, lockDetect, phaseMeasDone, freqSnapLoad, phaseSnapLoad;
    logic openLoopActive, preAcqActive, wideBwActive, dampingRelaxed, satStepLoad;
    logic holdoverAlarm;
    logic [3:0] refValid, refEnable, wantValid, lagCycles, satStepValue;
    logic [15:0] refPriority;
    logic [11:0] refGroup;
    logic [SLOPE_W-1:0] phaseSlopeLimitValue, fastLockSlopeLimit, activeSlopeLimit;
    logic [FREQ_W-2:0] maxFreqOffsetLimit, freqSnapSlopeLimit;
    logic [7:0] fastLockOptionEnables, lockCycles;
    logic [2:0] wideAcqLimitSelect;
    logic [BW_W-1:0] fastLockBandwidth, loopBandwidth, activeBandwidth;
    logic [MS_W-1:0] preAcqMs;
    logic [PHASE_W-1:0] phaseMeas, phaseFreqTerm, phaseDetRaw, phaseZero, phaseError;
    logic [PHASE_W-1:0] phaseSnapValue;
    logic [FREQ_W-1:0] freqOffsetMeas, freqRequest, freqSteer, freqSnapValue;
    logic [1:0] selectedRef;
    dsfc_state_t state;
    int bad_count, compares, satSteps;

    dsfc_switch_ctrl #(.MS_CYCLES(4)) dsfc_switch_ctrl_inst (.*);
    dsfc_ref_model dsfc_ref_model_inst (.*);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) if (satStepLoad === 1'b1) satSteps++;

    task automatic stop_test();
        if (bad_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // Bounded wait until the state is (or is no longer) the given one
    task automatic waitFor(dsfc_state_t s, logic on);
        int n;
        n = 0;
        @(negedge clk_sys);
        while ((state === s) !== on && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        chk(state === s, on);
    endtask
    function automatic logic [31:0] clampF(logic [31:0] req, logic [30:0] lim);
        if ($signed(req) > $signed({1'b0, lim})) return {1'b0, lim};
        if ($signed(req) < -$signed({1'b0, lim})) return -{1'b0, lim};
        return req;
    endfunction

    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        stop_test();
    end

    initial begin
        logic [30:0] lim;
        logic [31:0] req;
        int cnt;
        void'($urandom(87278));
        {revertiveEnable, hitlessEnable, hitlessType2, pslEnable, preAcqEnable} = 5'h00;
        reset = 1'b1;
        wantValid = 4'h0;
        lagCycles = 4'h2;
        lockCycles = 8'h06;
        refEnable = 4'hB;
        refPriority = 16'h4321;
        refGroup = 12'h009;
        phaseSlopeLimitValue = SLOPE_885NS;
        fastLockSlopeLimit = SLOPE_61US;
        maxFreqOffsetLimit = 31'h7FFFFFFF;
        freqSnapSlopeLimit = 31'h00000000;
        fastLockOptionEnables = 8'h63;
        wideAcqLimitSelect = 3'h3;
        fastLockBandwidth = 8'h80;
        loopBandwidth = 8'h10;
        preAcqMs = 8'h00;
        {phaseMeas, phaseFreqTerm, phaseDetRaw} = {$urandom(), $urandom(), $urandom()};
        freqOffsetMeas = $urandom();
        freqRequest = 32'h00000000;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        @(negedge clk_sys);
        chk(holdoverAlarm, 1);
        @(posedge clk_sys);
        wantValid <= 4'hC;
        waitFor(ST_ACQ, 1);
        chk(selectedRef, 3);
        chk({freqSnapLoad, phaseSnapLoad}, 2'b10);
        chk(freqSnapValue, clampF(freqOffsetMeas, maxFreqOffsetLimit));
        waitFor(ST_LOCKED, 1);
        @(posedge clk_sys);
        wantValid <= 4'hD;
        repeat (12) @(negedge clk_sys);
        chk(selectedRef, 3);
        @(posedge clk_sys);
        revertiveEnable <= 1'b1;
        lagCycles <= 4'($urandom_range(3));
        waitFor(ST_RELOCK, 1);
        chk(selectedRef, 0);
        chk({phaseSnapLoad, openLoopActive}, 2'b10);
        chk(phaseSnapValue, phaseDetRaw);
        waitFor(ST_LOCKED, 1);
        @(posedge clk_sys);
        wantValid <= 4'h2;
        waitFor(ST_LOCKED, 0);
        waitFor(ST_LOCKED, 1);
        chk(selectedRef, 1);
        @(posedge clk_sys);
        wantValid <= 4'h3;
        repeat (12) @(negedge clk_sys);
        chk(selectedRef, 1);
        @(posedge clk_sys);
        hitlessEnable <= 1'b1;
        phaseMeas <= $urandom();
        wantValid <= 4'h1;
        waitFor(ST_HITLESS, 1);
        chk(holdoverAlarm, 0);
        waitFor(ST_HITLESS, 0);
        @(negedge clk_sys);
        chk(phaseZero, phaseMeas);
        @(posedge clk_sys);
        phaseDetRaw <= $urandom();
        repeat (3) @(negedge clk_sys);
        chk(phaseError, phaseDetRaw - phaseMeas);
        chk(satSteps, 0);
        waitFor(ST_LOCKED, 1);
        @(posedge clk_sys);
        hitlessType2 <= 1'b1;
        phaseFreqTerm <= $urandom();
        wantValid <= 4'h0;
        waitFor(ST_HOLD, 1);
        chk(holdoverAlarm, 1);
        @(posedge clk_sys);
        wantValid <= 4'h1;
        waitFor(ST_HITLESS, 1);
        waitFor(ST_HITLESS, 0);
        @(negedge clk_sys);
        chk(phaseZero, phaseMeas - phaseFreqTerm);
        chk(satSteps > 0, 1);
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_sys);
            lim = (i < 4) ? 31'h00001000 : 31'($urandom() >> ($urandom() % 8));
            req = (i == 0) ? 32'h00001000 : (i == 1) ? 32'hFFFFF000 : $urandom();
            req = (i == 2) ? 32'h00001001 : (i == 3) ? 32'hFFFFEFFF : req;
            maxFreqOffsetLimit <= lim;
            freqRequest <= req;
            @(posedge clk_sys);
            @(negedge clk_sys);
            chk(freqSteer, clampF(req, lim));
        end
        @(posedge clk_sys);
        {hitlessEnable, pslEnable, preAcqEnable} <= 3'b011;
        fastLockOptionEnables <= 8'h08;
        preAcqMs <= 8'h02;
        lockCycles <= 8'd40;
        wantValid <= 4'h0;
        waitFor(ST_HOLD, 1);
        @(posedge clk_sys);
        wantValid <= 4'h1;
        waitFor(ST_ACQ, 1);
        cnt = 0;
        while (preAcqActive === 1'b1 && cnt < 50) begin
            cnt++;
            @(negedge clk_sys);
            if (cnt == 2) chk(activeBandwidth, BW_MAX);
        end
        chk(cnt, 8);
        @(negedge clk_sys);
        chk({wideBwActive, dampingRelaxed, activeBandwidth}, {2'b10, fastLockBandwidth});
        chk(activeSlopeLimit, fastLockSlopeLimit);
        waitFor(ST_LOCKED, 1);
        repeat (2) @(negedge clk_sys);
        chk({wideBwActive, activeBandwidth}, {1'b0, loopBandwidth});
        chk(activeSlopeLimit, phaseSlopeLimitValue);
        stop_test();
    end
endmodule // testbench
